//--- src/wdts_regs.vh
// Purpose: Register map, field layout and timing constants of the sleep-aware watchdog
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes: Included by the watchdog core only
//
// What this block does
// - Entering sleep clears the count, and counting restarts from zero if still enabled.
// - Leaving sleep clears the count and, with the start-up timer enabled, holds it at zero until the start-up timer ends.
// - An expiry in sleep wakes the device without reset and updates the status flags.
// - Mode always-off, or software mode with the enable bit low, keeps the watchdog cleared.
// - After a reset that wakes from sleep the count stays cleared until the start-up timer ends.
// - Interrupt wake, sleep entry, the clear instruction, oscillator failure and reset clear it.
// - Clock switches and divider changes leave the count and state untouched.
// - The two upper control bits read as zero.
// - Period field bits five to one select a prescale of 32 times two to the field value.
// - Period codes 10011 to 11111 give the minimum 1:32 prescale.
// - After reset the period field holds 01011, a 1:65536 prescale.
// - The software enable bit acts only in software mode and is ignored otherwise.
// - The prescaler counts ticks of the nominal 31 kHz low-frequency oscillator.
// - Control resets to period 01011 and enable 0 only at the synchronous reset i_reset_n.
// - An expiry while awake without a clear instruction generates a reset.
// - Mode 11 keeps the watchdog always active; mode 10 is active only while awake.
`ifndef WDTS_REGS_VH
`define WDTS_REGS_VH

`define WDTS_ADDR_CONTROL 4'h0
`define WDTS_ADDR_STATUS 4'h4
`define WDTS_ADDR_IRQ_STAT 4'h8
`define WDTS_ADDR_IRQ_MASK 4'hc

`define WDTS_CTRL_EN_BIT 0
`define WDTS_CTRL_PS_LSB 1
`define WDTS_CTRL_PS_MSB 5
`define WDTS_PS_RESET 5'h0b
`define WDTS_EN_RESET 1'h0
`define WDTS_PS_MAX 5'h12

`define WDTS_MODE_OFF 2'h0
`define WDTS_MODE_SW 2'h1
`define WDTS_MODE_AWAKE 2'h2
`define WDTS_MODE_ON 2'h3

`define WDTS_STAT_TO_N_BIT 4
`define WDTS_STAT_PD_N_BIT 3

`define WDTS_IRQ_WAKE_BIT 0
`define WDTS_IRQ_RESET_BIT 1

`define WDTS_SYS_HZ 25000000
`define WDTS_LFO_HZ 31000
`define WDTS_OST_TICKS 1024

`endif

//--- src/wdts_core.v
// Purpose: Sleep-aware watchdog timer with Avalon-MM register access
// Assumes: Single 25 MHz clock; the slow oscillator tick is a derived enable pulse
// Notes: Reset request and wake request are one-cycle pulses from flip-flops
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "wdts_regs.vh"

module wdts_core #(
    parameter integer SYS_HZ = `WDTS_SYS_HZ,
    parameter integer LFO_HZ = `WDTS_LFO_HZ,
    parameter integer OST_TICKS = `WDTS_OST_TICKS,
    parameter integer PRE_W = 24
) (
    input wire i_clk_sys, // System clock
    input wire i_reset_n, // Synchronous reset, active low
    input wire [3:0] i_avs_address, // Byte address
    input wire i_avs_read, // Read strobe
    input wire i_avs_write, // Write strobe
    input wire [31:0] i_avs_writedata, // Write data
    input wire [3:0] i_avs_byteenable, // Byte lanes
    input wire [1:0] i_enable_mode, // Configuration enable mode
    input wire i_sleep, // Device in sleep, level
    input wire i_clear_wdt, // Clear instruction pulse
    input wire i_int_wake, // Interrupt wake pulse
    input wire i_reset_wake, // Reset wake from sleep pulse
    input wire i_osc_fail, // Oscillator failure
    input wire i_ost_enable, // Start-up timer enabled
    output reg [31:0] o_avs_readdata, // Read data
    output reg o_avs_waitrequest, // Wait request
    output reg o_wdt_reset, // Reset request pulse
    output reg o_wdt_wake, // Wake request pulse
    output reg o_irq // Level interrupt
);

    localparam integer LFO_DIV = SYS_HZ / LFO_HZ;
    localparam integer DIV_W = 16;
    localparam [DIV_W-1:0] DIV_LAST = LFO_DIV[DIV_W-1:0] - 16'h0001;
    localparam [11:0] OST_LAST = OST_TICKS[11:0] - 12'h001;
    localparam [4:0] TAP_BASE = 5'h05;
    localparam [PRE_W-1:0] PRE_ONE = {{(PRE_W-1){1'b0}}, 1'b1};

    // Slow tick divider state
    reg [DIV_W-1:0] div_q;
    reg [DIV_W-1:0] div_d;
    reg lfo_tick_q;
    reg lfo_tick_d;

    // Prescaler and start-up timer state
    reg [PRE_W-1:0] pre_q;
    reg [PRE_W-1:0] pre_d;
    reg [11:0] ost_q;
    reg [11:0] ost_d;
    reg ost_run_q;
    reg ost_run_d;
    reg sleep_q;

    // Software visible state
    reg [4:0] ps_q;
    reg [4:0] ps_d;
    reg sw_en_q;
    reg sw_en_d;
    reg to_n_q;
    reg to_n_d;
    reg pd_n_q;
    reg pd_n_d;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_stat_d;
    reg [1:0] irq_mask_q;
    reg [1:0] irq_mask_d;

    // Bus and output next values
    reg ack_q;
    reg ack_d;
    reg wait_d;
    reg [31:0] rdata_d;
    reg irq_d;
    reg wdt_reset_d;
    reg wdt_wake_d;
    reg [7:0] ctrl_byte;
    reg [7:0] status_byte;

    // Decoded conditions
    reg active;
    reg [4:0] tap;
    reg [PRE_W-1:0] tap_mask;
    reg at_tap;
    reg expire;
    reg [1:0] ev;
    wire bus_req;
    wire bus_take;
    wire wr_ctrl;
    wire wr_mask;
    wire rd_stat;
    wire rd_any;
    wire sleep_in;
    wire sleep_out;
    wire ost_start;
    wire clr;

    // Bus request decode
    assign bus_req = i_avs_read | i_avs_write;
    assign bus_take = bus_req & ~ack_q;
    assign wr_ctrl = bus_take & i_avs_write & (i_avs_address == `WDTS_ADDR_CONTROL)
        & i_avs_byteenable[0];
    assign wr_mask = bus_take & i_avs_write & (i_avs_address == `WDTS_ADDR_IRQ_MASK)
        & i_avs_byteenable[0];
    assign rd_any = bus_take & i_avs_read;
    assign rd_stat = rd_any & (i_avs_address == `WDTS_ADDR_IRQ_STAT);

    // Sleep edges
    assign sleep_in = i_sleep & ~sleep_q;
    assign sleep_out = ~i_sleep & sleep_q;

    // A reset wake always waits out the start-up timer, a plain exit only if enabled
    assign ost_start = (sleep_out & i_ost_enable) | i_reset_wake;

    // Enable decode by mode
    always @* begin
        case (i_enable_mode)
            `WDTS_MODE_ON: begin
                active = 1'b1;
            end
            `WDTS_MODE_AWAKE: begin
                active = ~i_sleep;
            end
            `WDTS_MODE_SW: begin
                active = sw_en_q;
            end
            default: begin
                active = 1'b0;
            end
        endcase
    end

    // Tap select, reserved codes fall to minimum
    always @* begin
        if (ps_q > `WDTS_PS_MAX) begin
            tap = 5'h00;
        end else begin
            tap = ps_q;
        end
    end

    // Low prescaler bits that must all be one for the selected period
    always @* begin
        tap_mask = ~({PRE_W{1'b1}} << (tap + TAP_BASE));
        at_tap = ((pre_q & tap_mask) == tap_mask);
    end

    // Clearing events; clock switches are not inputs at all
    assign clr = ~active | sleep_in | sleep_out | i_clear_wdt | i_int_wake
        | i_reset_wake | i_osc_fail | ost_run_q;

    // Expiry and its split into wake or reset
    always @* begin
        expire = lfo_tick_q & active & ~clr & at_tap;
        ev = 2'b00;
        ev[`WDTS_IRQ_WAKE_BIT] = expire & i_sleep;
        ev[`WDTS_IRQ_RESET_BIT] = expire & ~i_sleep;
        wdt_wake_d = ev[`WDTS_IRQ_WAKE_BIT];
        wdt_reset_d = ev[`WDTS_IRQ_RESET_BIT];
    end

    // Slow oscillator tick divider
    always @* begin
        if (div_q == DIV_LAST) begin
            div_d = {DIV_W{1'b0}};
            lfo_tick_d = 1'b1;
        end else begin
            div_d = div_q + 16'h0001;
            lfo_tick_d = 1'b0;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            div_q <= {DIV_W{1'b0}};
            lfo_tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            lfo_tick_q <= lfo_tick_d;
        end
    end

    // Start-up timer, counts slow ticks after a wake
    always @* begin
        ost_run_d = ost_run_q;
        ost_d = ost_q;
        if (ost_start) begin
            ost_run_d = 1'b1;
            ost_d = 12'h000;
        end else if (ost_run_q & lfo_tick_q) begin
            if (ost_q == OST_LAST) begin
                ost_run_d = 1'b0;
            end
            ost_d = ost_q + 12'h001;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ost_q <= 12'h000;
            ost_run_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            ost_q <= ost_d;
            ost_run_q <= ost_run_d;
            sleep_q <= i_sleep;
        end
    end

    // Prescaler restarts from zero on every clearing event
    always @* begin
        if (clr | expire) begin
            pre_d = {PRE_W{1'b0}};
        end else if (lfo_tick_q) begin
            pre_d = pre_q + PRE_ONE;
        end else begin
            pre_d = pre_q;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            pre_q <= {PRE_W{1'b0}};
        end else begin
            pre_q <= pre_d;
        end
    end

    // Timeout and power-down flags, both active low
    always @* begin
        to_n_d = to_n_q;
        pd_n_d = pd_n_q;
        if (ev[`WDTS_IRQ_WAKE_BIT]) begin
            to_n_d = 1'b0;
            pd_n_d = 1'b0;
        end else if (ev[`WDTS_IRQ_RESET_BIT]) begin
            to_n_d = 1'b0;
            pd_n_d = 1'b1;
        end else if (i_clear_wdt) begin
            to_n_d = 1'b1;
            pd_n_d = 1'b1;
        end else if (sleep_in) begin
            pd_n_d = 1'b0;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
        end else begin
            to_n_q <= to_n_d;
            pd_n_q <= pd_n_d;
        end
    end

    // Control and mask registers
    always @* begin
        ps_d = ps_q;
        sw_en_d = sw_en_q;
        irq_mask_d = irq_mask_q;
        if (wr_ctrl) begin
            ps_d = i_avs_writedata[`WDTS_CTRL_PS_MSB:`WDTS_CTRL_PS_LSB];
            sw_en_d = i_avs_writedata[`WDTS_CTRL_EN_BIT];
        end
        if (wr_mask) begin
            irq_mask_d = i_avs_writedata[1:0];
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ps_q <= `WDTS_PS_RESET;
            sw_en_q <= `WDTS_EN_RESET;
            irq_mask_q <= 2'b00;
        end else begin
            ps_q <= ps_d;
            sw_en_q <= sw_en_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // Sticky event bits, read clears, a new event in that cycle wins
    always @* begin
        if (rd_stat) begin
            irq_stat_d = ev;
        end else begin
            irq_stat_d = irq_stat_q | ev;
        end
        irq_d = |((irq_stat_q | ev) & irq_mask_q);
    end

    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            irq_stat_q <= 2'b00;
            o_irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            o_irq <= irq_d;
        end
    end

    // Control byte, upper two bits unimplemented
    always @* begin
        ctrl_byte = 8'h00;
        ctrl_byte[`WDTS_CTRL_PS_MSB:`WDTS_CTRL_PS_LSB] = ps_q;
        ctrl_byte[`WDTS_CTRL_EN_BIT] = sw_en_q;
    end

    // Status byte as software sees it
    always @* begin
        status_byte = 8'h00;
        status_byte[`WDTS_STAT_TO_N_BIT] = to_n_q;
        status_byte[`WDTS_STAT_PD_N_BIT] = pd_n_q;
    end

    // Read mux, unmapped addresses return zero
    always @* begin
        rdata_d = o_avs_readdata;
        if (rd_any) begin
            case (i_avs_address)
                `WDTS_ADDR_CONTROL: begin
                    rdata_d = {24'h000000, ctrl_byte};
                end
                `WDTS_ADDR_STATUS: begin
                    rdata_d = {24'h000000, status_byte};
                end
                `WDTS_ADDR_IRQ_STAT: begin
                    rdata_d = {30'h0, irq_stat_q};
                end
                `WDTS_ADDR_IRQ_MASK: begin
                    rdata_d = {30'h0, irq_mask_q};
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // One wait cycle per access, then the strobe must drop or repeat
    always @* begin
        ack_d = bus_take;
        wait_d = ~bus_take;
    end

    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ack_q <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            o_avs_waitrequest <= wait_d;
            o_avs_readdata <= rdata_d;
        end
    end

    // Event pulses
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_wdt_reset <= 1'b0;
            o_wdt_wake <= 1'b0;
        end else begin
            o_wdt_reset <= wdt_reset_d;
            o_wdt_wake <= wdt_wake_d;
        end
    end

endmodule // wdts_core
`default_nettype wire

//--- testbench/wdts_checker.sv
// Purpose: Port assertions for the sleep-aware watchdog core
// Assumes: Bound to wdts_core, one clock domain
// Notes: Quiet windows are eight cycles long
`timescale 1ns/10ps
`default_nettype none
module wdts_checker (
    input wire i_clk_sys, // Clock
    input wire i_reset_n, // Reset
    input wire [3:0] i_avs_address, // Address
    input wire i_avs_read, // Read
    input wire [31:0] o_avs_readdata, // Read data
    input wire o_avs_waitrequest, // Wait
    input wire [1:0] i_enable_mode, // Mode
    input wire i_sleep, // Sleep
    input wire i_clear_wdt, // Clear
    input wire i_reset_wake, // Reset wake
    input wire o_wdt_reset, // Reset pulse
    input wire o_wdt_wake // Wake pulse
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_quiet;
        !o_wdt_reset [*8];
    endsequence
    a_wait_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_upper_bits_zero: assert property (!o_avs_waitrequest && i_avs_read
        && i_avs_address == 4'h0 |-> o_avs_readdata[7:6] == 2'h0)
        else $error("control upper bits not zero");
    a_reset_one_shot: assert property (o_wdt_reset |=> !o_wdt_reset)
        else $error("reset pulse too long");
    a_no_reset_asleep: assert property (o_wdt_reset |-> !$past(i_sleep))
        else $error("reset while asleep");
    a_wake_only_asleep: assert property (o_wdt_wake |-> $past(i_sleep))
        else $error("wake while awake");
    a_off_stays_quiet: assert property ($past(i_enable_mode, 2) == 2'h0
        && $past(i_enable_mode) == 2'h0 |-> !o_wdt_reset && !o_wdt_wake)
        else $error("expiry while off");
    a_awake_mode_sleeps: assert property ($past(i_enable_mode) == 2'h2
        && $past(i_sleep) |-> !o_wdt_wake)
        else $error("wake in awake-only mode");
    a_clear_holds_off: assert property (i_clear_wdt |-> ##2 s_quiet)
        else $error("expiry right after clear");
    a_exit_holds_off: assert property ($fell(i_sleep) |-> ##1 s_quiet)
        else $error("expiry right after sleep exit");
    a_wake_holds_off: assert property (i_reset_wake |-> ##1 s_quiet)
        else $error("expiry right after reset wake");
endmodule // wdts_checker
bind wdts_core wdts_checker wdts_checker_inst (.i_clk_sys, .i_reset_n, .i_avs_address,
    .i_avs_read, .o_avs_readdata, .o_avs_waitrequest, .i_enable_mode, .i_sleep,
    .i_clear_wdt, .i_reset_wake, .o_wdt_reset, .o_wdt_wake);
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench for the watchdog core
// Assumes: Slow tick every 4 clocks, start-up timer of 2 ticks
// Notes: Period code 0 expires about 128 clocks after a clear
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic i_clk_sys, i_reset_n, i_avs_read, i_avs_write, i_sleep, i_clear_wdt;
    logic i_int_wake, i_reset_wake, i_osc_fail, i_ost_enable;
    logic [3:0] i_avs_address;
    logic [31:0] i_avs_writedata, rd;
    logic [1:0] i_enable_mode;
    wire [31:0] o_avs_readdata;
    wire o_avs_waitrequest, o_wdt_reset, o_wdt_wake, o_irq;
    integer fail_count = 0, tests_run = 0, cyc = 0, n, m;
    wdts_core #(.SYS_HZ(8), .LFO_HZ(2), .OST_TICKS(2)) wdts_core_inst (.i_clk_sys, .i_reset_n,
        .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'hf),
        .i_enable_mode, .i_sleep, .i_clear_wdt, .i_int_wake, .i_reset_wake, .i_osc_fail,
        .i_ost_enable, .o_avs_readdata, .o_avs_waitrequest, .o_wdt_reset, .o_wdt_wake, .o_irq);
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= ~w;
        @(posedge i_clk_sys);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_clk_sys);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic wait_evt(input logic wk, input integer lim);
        n = 0;
        while ((wk ? o_wdt_wake : o_wdt_reset) !== 1'b1 && n < lim) begin
            @(posedge i_clk_sys);
            n = n + 1;
        end
    endtask
    task automatic t_regs;
        bus(0, 4'h0, 0);
        chk(rd, 32'h16);
        bus(0, 4'h4, 0);
        chk(rd[4:3], 2'h3);
        bus(1, 4'h0, 32'hff);
        bus(0, 4'h0, 0);
        chk(rd, 32'h3f);
        bus(0, 4'h2, 0);
        chk(rd, 0);
        bus(1, 4'hc, 32'h3);
    endtask
    task automatic t_expire(input logic [4:0] code);
        i_enable_mode <= 2'h1;
        bus(1, 4'h0, {code, 1'b1});
        wait_evt(0, 300);
        chk(n > 100 && n < 170, 1);
        bus(1, 4'h0, 0);
        chk(o_irq, 1);
        bus(0, 4'h4, 0);
        chk(rd[4:3], 2'h1);
        bus(0, 4'h8, 0);
        chk(rd[1:0], 2'h2);
        bus(0, 4'h8, 0);
        chk(rd[1:0], 2'h0);
        chk(o_irq, 0);
    endtask
    task automatic t_modes;
        for (m = 0; m < 4; m = m + 1) begin
            i_enable_mode <= m[1:0];
            bus(1, 4'h0, (m == 0) ? 32'h1 : 32'h0);
            wait_evt(0, 300);
            chk(n < 170, m >= 2);
            i_enable_mode <= 2'h0;
            bus(0, 4'h8, 0);
        end
    endtask
    task automatic t_sleep;
        i_enable_mode <= 2'h3;
        i_sleep <= 1'b1;
        wait_evt(1, 300);
        chk(n > 100 && n < 170, 1);
        i_sleep <= 1'b0;
        bus(0, 4'h4, 0);
        chk(rd[4:3], 2'h0);
        bus(0, 4'h8, 0);
        chk(rd[0], 1);
        i_enable_mode <= 2'h2;
        i_sleep <= 1'b1;
        wait_evt(1, 300);
        chk(n, 300);
        i_sleep <= 1'b0;
        wait_evt(0, 100);
        chk(n, 100);
    endtask
    task automatic t_clear;
        i_enable_mode <= 2'h3;
        for (m = 0; m < 8; m = m + 1) begin
            {i_reset_wake, i_osc_fail, i_int_wake, i_clear_wdt} <= 4'h1 << m[1:0];
            @(posedge i_clk_sys);
            {i_reset_wake, i_osc_fail, i_int_wake, i_clear_wdt} <= 4'h0;
            wait_evt(0, 90);
            chk(n, 90);
        end
        i_enable_mode <= 2'h0;
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            fail_count = fail_count + 1;
            complete_run;
        end
    end
    initial begin
        {i_reset_n, i_avs_read, i_avs_write, i_sleep, i_clear_wdt, i_int_wake} = 6'h0;
        {i_reset_wake, i_osc_fail, i_avs_address, i_avs_writedata, i_enable_mode} = 0;
        i_ost_enable = 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        t_regs;
        $display("test registers done");
        t_expire(5'h00);
        t_expire(5'h13);
        t_expire(5'h1f);
        $display("test expiry done");
        t_modes;
        $display("test modes done");
        t_sleep;
        $display("test sleep done");
        t_clear;
        $display("test clear done");
        complete_run;
    end
endmodule // tb
`default_nettype wire
